// >>> dv/lin_bus_node.sv
// Purpose: other node on the single-wire bus, with a pull-up.
// Assumes: bit time of BIT clocks, frames 8N1.
// Notes: pulls the line dominant during one chosen bit to force a collision.
`timescale 1ns/1ps
`default_nettype none
module lin_bus_node #(
   parameter int BIT = 16
) (
   input wire logic clk,
   input wire logic tx_pin,
   input wire logic pol,
   input wire logic [3:0] hit_bit,
   output logic rx_pin,
   output logic [7:0] got,
   output logic busy
);
   // -----
   // Model
   // -----
   int cnt = 0;
   logic [3:0] pos = 4'h0;
   logic was_low = 1'b0;
   // Position 0 is the start bit, 1 to 8 the data bits, 9 the stop bit.
   wire logic line = (tx_pin ^ pol) & !(busy && hit_bit != 4'h0 && pos == hit_bit);
   assign rx_pin = line ^ pol;
   initial busy = 1'b0;
   // A start needs two low clocks, so the one-clock dip when polarity flips while idle is ignored.
   always @(posedge clk) begin
      was_low <= !line;
      if (!busy) begin
         cnt <= 2;
         pos <= 4'h0;
         busy <= !line && was_low;
      end else begin
         cnt <= (cnt == BIT - 1) ? 0 : cnt + 1;
         if (cnt == BIT / 2 && pos != 4'h0 && pos != 4'h9) got[pos - 4'h1] <= line;
         if (cnt == BIT - 1) begin
            pos <= pos + 4'h1;
            busy <= pos != 4'h9;
         end
      end
   end
endmodule // lin_bus_node
`default_nettype wire

// >>> dv/lin_col_chk.sv
// Purpose: port assertions for the collision detector.
// Assumes: one clock, synchronous active-low reset.
// Notes: bound to every instance of the top module.
`timescale 1ns/1ps
`default_nettype none
module lin_col_chk (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [1:0] bit_error_mode_sel,
   input wire logic tx_polarity_invert,
   input wire logic bit_error_flag_clr,
   input wire logic tx_pin,
   input wire logic bit_error_flag,
   input wire logic tx_empty_flag,
   input wire logic tx_complete_flag,
   input wire logic tx_active
);
   // ----------
   // Assertions
   // ----------
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   wire logic en = (bit_error_mode_sel == 2'h1) || (bit_error_mode_sel == 2'h2);
   mode_gate_a:
      assert property (!en |=> !$rose(bit_error_flag)) else $error("flag set with checking off");
   idle_gate_a:
      assert property (!tx_active |=> !$rose(bit_error_flag)) else $error("flag set while idle");
   forced_bit_a:
      assert property ($rose(bit_error_flag) |-> tx_active && tx_pin == !tx_polarity_invert) else $error("no recessive bit");
   abort_flags_a:
      assert property ($rose(bit_error_flag) |-> tx_empty_flag && tx_complete_flag) else $error("status flags not set");
   flag_sticky_a:
      assert property (bit_error_flag && !bit_error_flag_clr && en |=> bit_error_flag) else $error("flag lost");
   start_block_a:
      assert property (bit_error_flag && !tx_active |=> !tx_active) else $error("frame started while flagged");
   mode_clear_a:
      assert property (!en |=> !bit_error_flag) else $error("flag kept with checking off");
   soft_clear_a:
      assert property (bit_error_flag_clr && !tx_active |=> !bit_error_flag) else $error("flag not cleared");
endmodule // lin_col_chk
bind lin_tx_collision_detect lin_col_chk u_chk (.clk, .rst_b, .bit_error_mode_sel, .tx_polarity_invert,
   .bit_error_flag_clr, .tx_pin, .bit_error_flag, .tx_empty_flag, .tx_complete_flag, .tx_active);
`default_nettype wire

// >>> dv/test_lin_tx_collision_detect.sv
// Purpose: self-checking bench for the collision detector.
// Assumes: 40 ns clock, bit time of 16 clocks.
// Notes: baud, sample point and the complete-flag clear are tied.
`timescale 1ns/1ps
`default_nettype none
module test_lin_tx_collision_detect;
   typedef struct {logic [1:0] mode; logic pol; logic [7:0] data; logic [3:0] hit; logic berr;} row_t;
   row_t rows [6] = '{'{2'h1, 1'b0, 8'ha5, 4'h0, 1'b0}, '{2'h2, 1'b1, 8'h3c, 4'h0, 1'b0},
      '{2'h0, 1'b0, 8'hff, 4'h3, 1'b0}, '{2'h3, 1'b1, 8'h81, 4'h8, 1'b0},
      '{2'h1, 1'b0, 8'hff, 4'h2, 1'b1}, '{2'h2, 1'b1, 8'hf0, 4'h5, 1'b1}};
   logic clk = 1'b0, rst_b = 1'b0, pol = 1'b0, clr = 1'b0, tx_valid = 1'b0, tdre = 1'b0;
   logic [1:0] mode = 2'h1;
   logic [7:0] tx_data = 8'h00;
   logic [3:0] hit = 4'h0;
   logic tx_ready, rx_pin, tx_pin, berr, empty, done, active, busy;
   logic [7:0] got;
   int err_total = 0;
   int checks_done = 0;
   int n, k;
   always #20 clk = !clk;
   // ------------
   // Test harness
   // ------------
   lin_tx_collision_detect u_dut (.clk, .rst_b, .bit_error_mode_sel(mode), .tx_polarity_invert(pol),
      .rx_polarity_invert(pol), .baud_div(16'h000f), .sample_point(16'h0008), .bit_error_flag_clr(clr),
      .tx_valid, .tx_ready, .tx_data, .tdre_clr(tdre), .tc_clr(1'b0), .rx_pin, .tx_pin,
      .bit_error_flag(berr), .tx_empty_flag(empty), .tx_complete_flag(done), .tx_active(active));
   lin_bus_node u_bus (.clk, .tx_pin, .pol, .hit_bit(hit), .rx_pin, .got, .busy);
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic cmp(input logic [7:0] a, input logic [7:0] e);
      checks_done++;
      if (a !== e) begin
         err_total++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e);
      end
   endtask
   // A wait that runs out is counted as a mismatch and ends the run.
   task automatic wait_on(ref logic s, input logic v);
      for (n = 0; n < 400 && s !== v; n++) @(negedge clk);
      if (s !== v) begin
         cmp(s, v);
         end_sim;
      end
   endtask
   // Pushes one byte; ready is registered, so one more cycle passes before it shows this push.
   task automatic push(input logic [7:0] d);
      @(posedge clk) begin tx_valid <= 1'b1; tx_data <= d; end
      @(posedge clk) tx_valid <= 1'b0;
      repeat (2) @(negedge clk);
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      @(negedge clk);
      cmp({active, berr, done, empty, tx_pin}, 8'h07);
      $display("reset check done");
      foreach (rows[i]) begin
         @(posedge clk) begin mode <= rows[i].mode; pol <= rows[i].pol; hit <= rows[i].hit; clr <= 1'b1; end
         @(posedge clk) clr <= 1'b0;
         wait_on(busy, 1'b0);
         push(rows[i].data);
         wait_on(active, 1'b1);
         wait_on(active, 1'b0);
         wait_on(busy, 1'b0);
         cmp(berr, rows[i].berr);
         if (!rows[i].berr) cmp(got, rows[i].data & ~8'((9'h001 << rows[i].hit) >> 1));
         $display("row %0d done", i);
      end
      @(posedge clk) begin pol <= 1'b0; hit <= 4'h0; end
      wait_on(busy, 1'b0);
      for (k = 0; k < 20 && tx_ready === 1'b1; k++) push(8'(k));
      cmp(8'(k), 8'h10);
      cmp(active, 1'b0);
      @(posedge clk) mode <= 2'h0;
      repeat (2) @(negedge clk);
      cmp(berr, 1'b0);
      repeat (16) begin
         wait_on(active, 1'b1);
         wait_on(active, 1'b0);
      end
      wait_on(busy, 1'b0);
      cmp(got, 8'h0f);
      $display("fill and drain done");
      @(posedge clk) begin mode <= 2'h1; hit <= 4'h1; end
      push(8'hff);
      push(8'h11);
      push(8'h22);
      @(posedge clk) tdre <= 1'b1;
      @(posedge clk) tdre <= 1'b0;
      @(negedge clk);
      cmp(empty, 1'b0);
      wait_on(berr, 1'b1);
      cmp({empty, done}, 8'h03);
      cmp(tx_pin, 1'b1);
      wait_on(active, 1'b0);
      @(posedge clk) clr <= 1'b1;
      @(posedge clk) clr <= 1'b0;
      repeat (40) @(negedge clk);
      cmp(berr, 1'b0);
      cmp(active, 1'b0);
      $display("abort flush done");
      end_sim;
   end
endmodule // test_lin_tx_collision_detect
`default_nettype wire

// >>> inc/lin_col_regs.vh
// Purpose: constants for the LIN transmit collision detector.
// Assumes: plain Verilog-2005, included by bare name.
// Notes: error-mode codes are two-bit field values.
`ifndef LIN_COL_REGS_VH
`define LIN_COL_REGS_VH
`define BERR_MODE_OFF 2'b00
`define BERR_MODE_A 2'b01
`define BERR_MODE_B 2'b10
`define BAUD_DIV_RST 16'h0010
`define SAMPLE_POINT_RST 16'h0008
`define FIFO_DEPTH_DEF 16
`define FIFO_AW_DEF 4
`endif

// >>> rtl/lin_tx_collision_detect.v
// Purpose: LIN transmitter with bit-error (collision) detection.
// Assumes: 25 MHz clk, rx pin asynchronous, software sets baud divider.
// Notes: frames are 8N1, LSB first; FIFO holds 16 pending bytes.
`timescale 1ns/1ps
`default_nettype none
`include "lin_col_regs.vh"
module lin_tx_collision_detect #(
   parameter DEPTH = `FIFO_DEPTH_DEF,
   parameter AW = `FIFO_AW_DEF
) (
   input wire clk,
   input wire rst_b,
   input wire [1:0] bit_error_mode_sel,
   input wire tx_polarity_invert,
   input wire rx_polarity_invert,
   input wire [15:0] baud_div,
   input wire [15:0] sample_point,
   input wire bit_error_flag_clr,
   input wire tx_valid,
   output reg tx_ready,
   input wire [7:0] tx_data,
   input wire tdre_clr,
   input wire tc_clr,
   input wire rx_pin,
   output reg tx_pin,
   output reg bit_error_flag,
   output reg tx_empty_flag,
   output reg tx_complete_flag,
   output reg tx_active
);
   // ----------------------------------------------------------------
   // States
   // ----------------------------------------------------------------
   localparam [2:0] S_IDLE = 3'b001;
   localparam [2:0] S_SEND = 3'b010;
   localparam [2:0] S_RECV = 3'b100;

   reg [2:0] st_q;
   reg [2:0] st_d;
   reg [15:0] tick_q;
   reg [3:0] bit_q;
   reg [9:0] shift_q;
   reg forced_q;
   reg rx_s1_q;
   reg rx_s2_q;
   reg rx_s3_q;
   reg rx_lvl_q;
   wire fifo_ready;
   wire fifo_valid;
   wire [7:0] fifo_data;
   wire fifo_pop;
   wire chk_en;
   wire bit_end;
   wire sample;
   wire mismatch;
   wire sent_bit;

   // ----------------------------------------------------------------
   // Buffer
   // ----------------------------------------------------------------
   tx_fifo #(.WIDTH(8), .DEPTH(DEPTH), .AW(AW)) u_fifo (
      .clk(clk),
      .rst_b(rst_b),
      .flush(mismatch),
      .in_valid(tx_valid),
      .in_ready(fifo_ready),
      .in_data(tx_data),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_data)
   );

   // ----------------------------------------------------------------
   // Receive path
   // ----------------------------------------------------------------
   // The filtered level changes only when the 2nd and 3rd stages agree.
   always @(posedge clk) begin
      if (!rst_b) begin
         rx_s1_q <= 1'b1;
         rx_s2_q <= 1'b1;
         rx_s3_q <= 1'b1;
         rx_lvl_q <= 1'b1;
      end else begin
         rx_s1_q <= rx_pin;
         rx_s2_q <= rx_s1_q;
         rx_s3_q <= rx_s2_q;
         if (rx_s2_q == rx_s3_q) begin
            rx_lvl_q <= rx_s3_q ^ rx_polarity_invert;
         end
      end
   end

   // ----------------------------------------------------------------
   // Checking
   // ----------------------------------------------------------------
   assign chk_en = (bit_error_mode_sel == `BERR_MODE_A) ||
                   (bit_error_mode_sel == `BERR_MODE_B);
   assign bit_end = (tick_q == baud_div);
   assign sample = (tick_q == sample_point);
   assign sent_bit = shift_q[0];
   // Comparison is on logical data, so both polarities must match.
   assign mismatch = chk_en && (st_q == S_SEND) && sample &&
                     !forced_q && (sent_bit != rx_lvl_q);
   // Popping is blocked while the error flag stands.
   assign fifo_pop = (st_q == S_IDLE) && fifo_valid && !bit_error_flag;

   always @* begin
      st_d = st_q;
      case (st_q)
         S_IDLE: begin
            if (fifo_pop) begin
               st_d = S_SEND;
            end
         end
         S_SEND: begin
            if (mismatch) begin
               st_d = S_RECV;
            end else if (bit_end && bit_q == 4'h9) begin
               st_d = S_IDLE;
            end
         end
         S_RECV: begin
            if (bit_end) begin
               st_d = S_IDLE;
            end
         end
         default: begin
            st_d = S_IDLE;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Transmitter
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      if (!rst_b) begin
         st_q <= S_IDLE;
         tick_q <= 16'h0000;
         bit_q <= 4'h0;
         shift_q <= 10'h3ff;
         forced_q <= 1'b0;
         tx_pin <= 1'b1;
         tx_active <= 1'b0;
         tx_ready <= 1'b0;
      end else begin
         st_q <= st_d;
         tx_ready <= fifo_ready;
         tx_active <= (st_d != S_IDLE);
         if (st_q == S_IDLE) begin
            tick_q <= 16'h0000;
            bit_q <= 4'h0;
            forced_q <= 1'b0;
            if (fifo_pop) begin
               shift_q <= {1'b1, fifo_data, 1'b0};
            end
         end else if (mismatch) begin
            // Recessive bit after a collision, held one full bit time.
            tick_q <= 16'h0000;
            forced_q <= 1'b1;
            shift_q <= 10'h3ff;
         end else if (bit_end) begin
            tick_q <= 16'h0000;
            bit_q <= bit_q + 4'h1;
            shift_q <= {1'b1, shift_q[9:1]};
         end else begin
            tick_q <= tick_q + 16'h0001;
         end
         if (st_d == S_IDLE) begin
            tx_pin <= ~tx_polarity_invert;
         end else if (mismatch) begin
            tx_pin <= ~tx_polarity_invert;
         end else if (st_q == S_IDLE) begin
            tx_pin <= tx_polarity_invert;
         end else if (bit_end) begin
            tx_pin <= shift_q[1] ^ tx_polarity_invert;
         end
      end
   end

   // ----------------------------------------------------------------
   // Status flags (set wins over clear)
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      if (!rst_b) begin
         bit_error_flag <= 1'b0;
         tx_empty_flag <= 1'b1;
         tx_complete_flag <= 1'b1;
      end else begin
         if (mismatch) begin
            bit_error_flag <= 1'b1;
         end else if (!chk_en) begin
            bit_error_flag <= 1'b0;
         end else if (bit_error_flag_clr) begin
            bit_error_flag <= 1'b0;
         end
         if (mismatch || !fifo_valid) begin
            tx_empty_flag <= 1'b1;
         end else if (tdre_clr) begin
            tx_empty_flag <= 1'b0;
         end
         if (mismatch || (st_q == S_SEND && st_d == S_IDLE)) begin
            tx_complete_flag <= 1'b1;
         end else if (tc_clr || fifo_pop) begin
            tx_complete_flag <= 1'b0;
         end
      end
   end
endmodule // lin_tx_collision_detect
`default_nettype wire

// >>> rtl/tx_fifo.v
// Purpose: synchronous FIFO with valid/ready on both sides.
// Assumes: one clock, synchronous active-low reset.
// Notes: flush empties the FIFO in one cycle.
`timescale 1ns/1ps
`default_nettype none
module tx_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   input wire clk,
   input wire rst_b,
   input wire flush,
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_q;
   reg [AW-1:0] rd_q;
   reg [AW:0] cnt_q;
   wire push;
   wire pop;
   assign in_ready = (cnt_q != DEPTH[AW:0]);
   assign out_valid = (cnt_q != {(AW+1){1'b0}});
   assign out_data = mem[rd_q];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   always @(posedge clk) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
   end
   always @(posedge clk) begin
      if (!rst_b || flush) begin
         wr_q <= {AW{1'b0}};
         rd_q <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule // tx_fifo
`default_nettype wire
